// file: hw/lcp_pkg.sv
/*
  Shared constants of the LED driver serial control port.
  Assumes a 100 MHz system clock on both ends.
*/
package lcp_pkg;
  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h33;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] HS_CODE = 8'h08;
  localparam logic [2:0] REG_LIGHT = 3'h0;
  localparam logic [2:0] REG_FLASH2 = 3'h1;
  localparam logic [2:0] REG_FLASH13 = 3'h2;

  // ----------------------------------------
  // Register fields and defaults
  // ----------------------------------------
  localparam int RESET_BIT = 7;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int VREG_EN_BIT = 5;
  localparam logic [7:0] DEF_LIGHT = 8'h0A;
  localparam logic [7:0] DEF_FLASH2 = 8'h10;
  localparam logic [7:0] DEF_FLASH13 = 8'h08;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_VIDEO = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VSRC = 2'h3;

  // ----------------------------------------
  // Bus timing (quarter bit periods)
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int STD_PERIOD_NS = 10000;
  localparam int FAST_PERIOD_NS = 2500;
  localparam int HS_PERIOD_NS = 295;
  localparam logic [7:0] Q_STD = 8'((STD_PERIOD_NS * CLK_MHZ + 3999) / 4000);
  localparam logic [7:0] Q_FAST = 8'((FAST_PERIOD_NS * CLK_MHZ + 3999) / 4000);
  localparam logic [7:0] Q_HS = 8'((HS_PERIOD_NS * CLK_MHZ + 3999) / 4000);
endpackage

// file: hw/lcp_link_if.sv
/*
  Two-wire link between host and LED driver, plus the hardware reset line.
  Open-drain wires are resolved here with pull-ups; no clock stretching.
*/
`timescale 1ns/100ps
interface lcp_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic hw_reset_n;
  logic scl;
  logic sda;

  // Pull-ups win unless a party enables its low driver
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, input hw_reset_n, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                output host_sda_o, output host_sda_oe_n, output hw_reset_n);
endinterface // lcp_link_if

// file: hw/lcp_host.sv
/*
  Bus master end: runs single register writes and reads on command.
  Assumes the slave never stretches the clock.
*/
`timescale 1ns/100ps
module lcp_host (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  lcp_link_if.host link,
  input wire logic hw_reset_req_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic cmd_fast_i,
  input wire logic cmd_hs_i,
  input wire logic [2:0] cmd_ptr_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rd_data_o
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} lcp_host_state_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  lcp_host_state_t st_r, st_nxt;
  logic [1:0] q_r, q_nxt;
  logic [7:0] div_r, div_nxt;
  logic [2:0] step_r, step_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, rd_r, rd_nxt;
  logic [7:0] data_r, data_nxt;
  logic [2:0] ptr_r, ptr_nxt;
  logic read_r, read_nxt, fast_r, fast_nxt, hs_r, hs_nxt;
  logic ack_r, ack_nxt, nack_r, nack_nxt;
  logic scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
  logic ready_r, ready_nxt, done_r, done_nxt, rstn_r;
  logic sda_s1_r, sda_s2_r;
  logic [7:0] qlim;
  logic tick;

  // Byte sent in each step of a transfer
  function automatic logic [7:0] step_byte(input logic [2:0] s, input logic rd,
                                           input logic [2:0] p, input logic [7:0] d);
    unique case (s)
      3'h0: step_byte = lcp_pkg::HS_CODE;
      3'h1: step_byte = {lcp_pkg::SLAVE_ADDR, 1'b0};
      3'h2: step_byte = {5'h00, p};
      3'h3: step_byte = rd ? {lcp_pkg::SLAVE_ADDR, 1'b1} : d;
      default: step_byte = 8'h00;
    endcase
  endfunction

  // Master code goes at the F/S rate, the address and the rest at HS when asked
  assign qlim = hs_r ? lcp_pkg::Q_HS : (fast_r ? lcp_pkg::Q_FAST : lcp_pkg::Q_STD);
  assign tick = (st_r != H_IDLE) && (div_r == 8'h00);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r; q_nxt = q_r; div_nxt = div_r; step_nxt = step_r; bit_nxt = bit_r;
    tx_nxt = tx_r; rx_nxt = rx_r; rd_nxt = rd_r; data_nxt = data_r; ptr_nxt = ptr_r;
    read_nxt = read_r; fast_nxt = fast_r; hs_nxt = hs_r; ack_nxt = ack_r; nack_nxt = nack_r;
    scl_low_nxt = scl_low_r; sda_low_nxt = sda_low_r; ready_nxt = ready_r; done_nxt = 1'b0;
    if (st_r != H_IDLE) begin
      div_nxt = tick ? qlim - 8'h01 : div_r - 8'h01;
    end
    if (st_r == H_IDLE) begin
      if (cmd_valid_i && ready_r) begin
        st_nxt = H_START; q_nxt = 2'h0; div_nxt = 8'h00; ready_nxt = 1'b0; nack_nxt = 1'b0;
        read_nxt = cmd_read_i; fast_nxt = cmd_fast_i; ptr_nxt = cmd_ptr_i; data_nxt = cmd_data_i;
        step_nxt = cmd_hs_i ? 3'h0 : 3'h1;
      end
    end else if (tick) begin
      q_nxt = q_r + 2'h1;
      unique case (st_r)
        H_START: begin
          // Release data, raise clock, then pull data low while clock high
          if (q_r == 2'h0) sda_low_nxt = 1'b0;
          if (q_r == 2'h1) scl_low_nxt = 1'b0;
          if (q_r == 2'h2) sda_low_nxt = 1'b1;
          if (q_r == 2'h3) begin
            scl_low_nxt = 1'b1; st_nxt = H_BIT; bit_nxt = 4'h0;
            tx_nxt = step_byte(step_r, read_r, ptr_r, data_r);
          end
        end
        H_BIT: begin
          // Data changes only with the clock low
          if (q_r == 2'h0) sda_low_nxt = (step_r == 3'h4) ? (bit_r == 4'h8 ? 1'b0 : 1'b0)
                                                         : (bit_r != 4'h8 && !tx_r[7]);
          if (q_r == 2'h1) scl_low_nxt = 1'b0;
          if (q_r == 2'h2) begin
            if (bit_r == 4'h8) ack_nxt = ~sda_s2_r;
            else rx_nxt = {rx_r[6:0], sda_s2_r};
          end
          if (q_r == 2'h3) begin
            scl_low_nxt = 1'b1;
            if (bit_r != 4'h8) begin
              bit_nxt = bit_r + 4'h1; tx_nxt = {tx_r[6:0], 1'b0};
            end else if (step_r == 3'h0) begin
              hs_nxt = 1'b1; st_nxt = H_START; step_nxt = 3'h1;
            end else if (step_r != 3'h4 && !ack_r) begin
              nack_nxt = 1'b1; st_nxt = H_STOP;
            end else if (step_r == 3'h2 && read_r) begin
              st_nxt = H_START; step_nxt = 3'h3;
            end else if (step_r == 3'h4 || (step_r == 3'h3 && !read_r)) begin
              st_nxt = H_STOP; rd_nxt = rx_r;
            end else begin
              step_nxt = step_r + 3'h1; bit_nxt = 4'h0;
              tx_nxt = step_byte(step_r + 3'h1, read_r, ptr_r, data_r);
            end
          end
        end
        H_STOP: begin
          if (q_r == 2'h0) sda_low_nxt = 1'b1;
          if (q_r == 2'h1) scl_low_nxt = 1'b0;
          if (q_r == 2'h2) sda_low_nxt = 1'b0;
          if (q_r == 2'h3) begin
            st_nxt = H_IDLE; hs_nxt = 1'b0; ready_nxt = 1'b1; done_nxt = 1'b1;
          end
        end
        H_IDLE: st_nxt = H_IDLE;
      endcase
    end
  end

  // Registers; the reset line is only driven low on request
  always_ff @(posedge clk_sys_i) begin
    sda_s1_r <= link.sda;
    sda_s2_r <= sda_s1_r;
    if (rst_i) begin
      st_r <= H_IDLE; q_r <= 2'h0; div_r <= 8'h00; step_r <= 3'h0; bit_r <= 4'h0;
      tx_r <= 8'h00; rx_r <= 8'h00; rd_r <= 8'h00; data_r <= 8'h00; ptr_r <= 3'h0;
      read_r <= 1'b0; fast_r <= 1'b0; hs_r <= 1'b0; ack_r <= 1'b0; nack_r <= 1'b0;
      scl_low_r <= 1'b0; sda_low_r <= 1'b0; ready_r <= 1'b1; done_r <= 1'b0; rstn_r <= 1'b1;
    end else begin
      st_r <= st_nxt; q_r <= q_nxt; div_r <= div_nxt; step_r <= step_nxt; bit_r <= bit_nxt;
      tx_r <= tx_nxt; rx_r <= rx_nxt; rd_r <= rd_nxt; data_r <= data_nxt; ptr_r <= ptr_nxt;
      read_r <= read_nxt; fast_r <= fast_nxt; hs_r <= hs_nxt; ack_r <= ack_nxt; nack_r <= nack_nxt;
      scl_low_r <= scl_low_nxt; sda_low_r <= sda_low_nxt; ready_r <= ready_nxt; done_r <= done_nxt;
      rstn_r <= ~hw_reset_req_i;
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe_n = ~scl_low_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = ~sda_low_r;
  assign link.hw_reset_n = rstn_r;
  assign cmd_ready_o = ready_r;
  assign done_o = done_r;
  assign nack_o = nack_r;
  assign rd_data_o = rd_r;
endmodule // lcp_host

// file: hw/lcp_device.sv
/*
  Slave end of the LED driver control port: address match, register
  pointer, write commit, read back and the shutdown decision.
  Assumes the master drives SCL; SCL and SDA are sampled by clk_sys_i.
*/
`timescale 1ns/100ps
module lcp_device (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  lcp_link_if.dev link,
  output logic [1:0] mode_o,
  output logic voltage_regulation_en_o,
  output logic shutdown_o,
  output logic conv_switch_en_o,
  output logic load_connect_o,
  output logic led_sink_pins_hiz_o,
  output logic out_discharge_o,
  output logic high_speed_mode_o,
  output logic [7:0] cfg_light_o,
  output logic [7:0] cfg_flash2_o,
  output logic [7:0] cfg_flash13_o
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_DATA, ST_DATA_ACK,
    ST_TX, ST_TX_ACK, ST_IGNORE
  } lcp_dev_state_t;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;
  logic rstn_s1_r, rstn_s2_r;
  logic rst_all, scl_rise, scl_fall, start_det, stop_det;
  lcp_dev_state_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt, ptr_r, ptr_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic rw_r, rw_nxt, mack_r, mack_nxt;
  logic sda_low_r, sda_low_nxt, hs_r, hs_nxt, wr_en;
  logic [7:0] r0_r, r0_nxt, r1_r, r1_nxt, r2_r, r2_nxt;
  logic shut_nxt;

  // Read back value of a register pointer
  function automatic logic [7:0] rd_byte(input logic [2:0] p, input logic [7:0] a,
                                         input logic [7:0] b, input logic [7:0] c);
    unique case (p)
      lcp_pkg::REG_LIGHT: rd_byte = a;
      lcp_pkg::REG_FLASH2: rd_byte = b;
      lcp_pkg::REG_FLASH13: rd_byte = c;
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // Synchronisers and bus conditions
  // ----------------------------------------
  // Pins and the reset line come from another domain: two flops first
  always_ff @(posedge clk_sys_i) begin
    scl_s1_r <= link.scl;
    scl_s2_r <= scl_s1_r;
    scl_s3_r <= scl_s2_r;
    sda_s1_r <= link.sda;
    sda_s2_r <= sda_s1_r;
    sda_s3_r <= sda_s2_r;
    rstn_s1_r <= link.hw_reset_n;
    rstn_s2_r <= rstn_s1_r;
  end

  // Pin reset acts exactly like the system reset on all state
  assign rst_all = rst_i | ~rstn_s2_r;
  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  // Data edges with clock high are conditions, never data
  assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  // Bits are taken on clock rise; SDA is only changed after a clock fall
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    sh_nxt = sh_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    sda_low_nxt = sda_low_r;
    hs_nxt = hs_r;
    wr_en = 1'b0;
    if (start_det) begin
      st_nxt = ST_START;
      cnt_nxt = 3'h0;
      sda_low_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt = ST_IDLE;
      sda_low_nxt = 1'b0;
      hs_nxt = 1'b0;
    end else begin
      unique case (st_r)
        // The clock fall that closes a start is not a data bit
        ST_START: begin
          if (scl_fall) begin
            st_nxt = ST_ADDR;
            cnt_nxt = 3'h0;
          end
        end
        ST_ADDR, ST_PTR, ST_DATA: begin
          if (scl_rise) sh_nxt = {sh_r[6:0], sda_s2_r};
          if (scl_fall && cnt_r != 3'h7) cnt_nxt = cnt_r + 3'h1;
          if (scl_fall && cnt_r == 3'h7) begin
            cnt_nxt = 3'h0;
            if (st_r == ST_ADDR) begin
              if (sh_r[7:1] == lcp_pkg::SLAVE_ADDR) begin
                sda_low_nxt = 1'b1;
                rw_nxt = sh_r[0];
                st_nxt = ST_ADDR_ACK;
              end else begin
                // Master code is recognised but never acknowledged
                if (sh_r[7:3] == lcp_pkg::HS_CODE_TOP) hs_nxt = 1'b1;
                st_nxt = ST_IGNORE;
              end
            end else if (st_r == ST_PTR) begin
              ptr_nxt = sh_r[2:0];
              sda_low_nxt = 1'b1;
              st_nxt = ST_PTR_ACK;
            end else begin
              sda_low_nxt = 1'b1;
              st_nxt = ST_DATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              st_nxt = ST_TX;
              sh_nxt = rd_byte(ptr_r, r0_r, r1_r, r2_r);
              sda_low_nxt = ~sh_nxt[7];
            end else begin
              st_nxt = ST_PTR;
              sda_low_nxt = 1'b0;
            end
          end
        end
        ST_PTR_ACK: begin
          if (scl_fall) begin
            st_nxt = ST_DATA;
            sda_low_nxt = 1'b0;
          end
        end
        ST_DATA_ACK: begin
          if (scl_fall) begin
            wr_en = 1'b1;
            st_nxt = ST_DATA;
            sda_low_nxt = 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall && cnt_r == 3'h7) begin
            st_nxt = ST_TX_ACK;
            cnt_nxt = 3'h0;
            sda_low_nxt = 1'b0;
          end else if (scl_fall) begin
            cnt_nxt = cnt_r + 3'h1;
            sh_nxt = {sh_r[6:0], 1'b0};
            sda_low_nxt = ~sh_r[6];
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) mack_nxt = ~sda_s2_r;
          if (scl_fall && mack_r) begin
            st_nxt = ST_TX;
            sh_nxt = rd_byte(ptr_r, r0_r, r1_r, r2_r);
            sda_low_nxt = ~sh_nxt[7];
          end else if (scl_fall) begin
            st_nxt = ST_IGNORE;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_low_nxt = 1'b0;
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      st_r <= ST_IDLE;
      cnt_r <= 3'h0;
      ptr_r <= 3'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      sda_low_r <= 1'b0;
      hs_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      sh_r <= sh_nxt;
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
      sda_low_r <= sda_low_nxt;
      hs_r <= hs_nxt;
    end
  end

  // ----------------------------------------
  // Control registers and power state
  // ----------------------------------------
  // The reset bit self-clears, so it always reads back as zero
  always_comb begin
    r0_nxt = r0_r;
    r1_nxt = r1_r;
    r2_nxt = r2_r;
    if (wr_en) begin
      unique case (ptr_r)
        lcp_pkg::REG_LIGHT: begin
          if (sh_r[lcp_pkg::RESET_BIT]) begin
            r0_nxt = lcp_pkg::DEF_LIGHT;
            r1_nxt = lcp_pkg::DEF_FLASH2;
            r2_nxt = lcp_pkg::DEF_FLASH13;
          end else begin
            r0_nxt = {1'b0, sh_r[6:0]};
          end
        end
        lcp_pkg::REG_FLASH2: begin
          r1_nxt = sh_r;
          // Mode bits are copied into FLASH13; a FLASH13 write does not copy them back here
          r2_nxt[lcp_pkg::MODE_MSB:lcp_pkg::MODE_LSB] = sh_r[lcp_pkg::MODE_MSB:lcp_pkg::MODE_LSB];
        end
        lcp_pkg::REG_FLASH13: r2_nxt = sh_r;
        default: r0_nxt = r0_r; // Unimplemented pointers drop writes
      endcase
    end
    // Lights off is mode 00, regulator off is its enable bit clear
    shut_nxt = (r2_nxt[lcp_pkg::MODE_MSB:lcp_pkg::MODE_LSB] == lcp_pkg::MODE_SHUTDOWN) &&
               !r2_nxt[lcp_pkg::VREG_EN_BIT];
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      r0_r <= lcp_pkg::DEF_LIGHT;
      r1_r <= lcp_pkg::DEF_FLASH2;
      r2_r <= lcp_pkg::DEF_FLASH13;
      shutdown_o <= 1'b1;
      conv_switch_en_o <= 1'b0;
      load_connect_o <= 1'b0;
      led_sink_pins_hiz_o <= 1'b1;
      out_discharge_o <= 1'b1;
      mode_o <= lcp_pkg::MODE_SHUTDOWN;
      voltage_regulation_en_o <= 1'b0;
      high_speed_mode_o <= 1'b0;
    end else begin
      r0_r <= r0_nxt;
      r1_r <= r1_nxt;
      r2_r <= r2_nxt;
      shutdown_o <= shut_nxt;
      conv_switch_en_o <= ~shut_nxt;
      load_connect_o <= ~shut_nxt;
      led_sink_pins_hiz_o <= shut_nxt;
      out_discharge_o <= shut_nxt;
      mode_o <= r2_nxt[lcp_pkg::MODE_MSB:lcp_pkg::MODE_LSB];
      voltage_regulation_en_o <= r2_nxt[lcp_pkg::VREG_EN_BIT];
      high_speed_mode_o <= hs_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = ~sda_low_r;
  assign cfg_light_o = r0_r;
  assign cfg_flash2_o = r1_r;
  assign cfg_flash13_o = r2_r;
endmodule // lcp_device

// file: testbench/lcp_link_monitor.sv
/*
  Assertion checker watching the two-wire link between host and device.
  Assumes the interface resolves the open-drain wires; one clock domain.
*/
`timescale 1ns/100ps
module lcp_link_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic hw_reset_n,
  input wire logic dev_sda_oe_n
);
  logic scl_d_r, sda_d_r, first_r, first_nxt, wr_r, wr_nxt, rd_r, rd_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic rise, start, stop, ninth, match;

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  // Edges seen on the raw wires, two clocks ahead of the device's view
  assign rise = scl & ~scl_d_r;
  assign start = scl & scl_d_r & sda_d_r & ~sda;
  assign stop = scl & scl_d_r & ~sda_d_r & sda;
  assign ninth = rise & (cnt_r == 4'h8);
  assign match = (sh_r[7:1] == lcp_pkg::SLAVE_ADDR);

  // Bit count, byte shifter and direction of the addressed transfer
  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    first_nxt = first_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (start) begin
      cnt_nxt = 4'h0;
      first_nxt = 1'b1;
      wr_nxt = 1'b0;
      rd_nxt = 1'b0;
    end else if (ninth) begin
      cnt_nxt = 4'h0;
      first_nxt = 1'b0;
      if (first_r) begin
        wr_nxt = match & ~sh_r[0];
        rd_nxt = match & sh_r[0];
      end
    end else if (rise) begin
      cnt_nxt = cnt_r + 4'h1;
      sh_nxt = {sh_r[6:0], sda};
    end
  end

  // Registers only; idle wires read high
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      first_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      first_r <= first_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sda_stable_a: assert property ((scl && scl_d_r) |-> $stable(dev_sda_oe_n))
    else $error("device changed data line while clock high");
  hw_reset_a: assert property (!hw_reset_n [*4] |-> dev_sda_oe_n)
    else $error("device drives link during hardware reset");
  start_quiet_a: assert property (start |-> dev_sda_oe_n [*8])
    else $error("device drives right after start");
  stop_release_a: assert property (stop |=> dev_sda_oe_n [*8])
    else $error("device holds link after stop");
  addr_ack_a: assert property (ninth && first_r && match |-> !dev_sda_oe_n)
    else $error("own address not acknowledged");
  code_nack_a: assert property (ninth && first_r && !match |-> dev_sda_oe_n)
    else $error("foreign address or master code acknowledged");
  write_ack_a: assert property (ninth && !first_r && wr_r |-> !dev_sda_oe_n ##1 !dev_sda_oe_n)
    else $error("written byte not acknowledged");
  read_nack_a: assert property (ninth && !first_r && rd_r |-> sda && dev_sda_oe_n)
    else $error("device holds line on master acknowledge slot");

  // Main scenarios reached
  addr_ack_c: cover property (ninth && first_r && match);
  code_nack_c: cover property (ninth && first_r && !match);
  read_end_c: cover property (ninth && !first_r && rd_r);
endmodule // lcp_link_monitor

// file: testbench/led_driver_serial_control_port_tb_top.sv
/*
  Testbench joining host and device over the link interface.
  Assumes the host runs one command at a time and ends each with a stop.
*/
`timescale 1ns/100ps
module led_driver_serial_control_port_tb_top;
  localparam int LIM = 40000;
  localparam logic [7:0] PWR_OFF = 8'h13;
  localparam logic [7:0] PWR_ON = 8'h0C;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, hw_reset_req_i = 1'b0;
  logic cmd_valid_i = 1'b0, cmd_read_i = 1'b0, cmd_fast_i = 1'b0, cmd_hs_i = 1'b0;
  logic [2:0] cmd_ptr_i = 3'h0;
  logic [7:0] cmd_data_i = 8'h00;
  logic cmd_ready_o, done_o, nack_o, voltage_regulation_en_o, shutdown_o, conv_switch_en_o;
  logic load_connect_o, led_sink_pins_hiz_o, out_discharge_o, high_speed_mode_o, nk, hs;
  logic [1:0] mode_o;
  logic [7:0] rd_data_o, cfg_light_o, cfg_flash2_o, cfg_flash13_o, rd;
  int n_fail = 0;
  int total_checks = 0;

  // ----------------------------------------
  // Ends, link and checker
  // ----------------------------------------
  lcp_link_if lcp_link_if_inst ();
  lcp_host lcp_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(lcp_link_if_inst),
    .hw_reset_req_i(hw_reset_req_i), .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i),
    .cmd_fast_i(cmd_fast_i), .cmd_hs_i(cmd_hs_i), .cmd_ptr_i(cmd_ptr_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o), .rd_data_o(rd_data_o));
  lcp_device lcp_device_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(lcp_link_if_inst),
    .mode_o(mode_o), .voltage_regulation_en_o(voltage_regulation_en_o), .shutdown_o(shutdown_o),
    .conv_switch_en_o(conv_switch_en_o), .load_connect_o(load_connect_o),
    .led_sink_pins_hiz_o(led_sink_pins_hiz_o), .out_discharge_o(out_discharge_o),
    .high_speed_mode_o(high_speed_mode_o), .cfg_light_o(cfg_light_o), .cfg_flash2_o(cfg_flash2_o),
    .cfg_flash13_o(cfg_flash13_o));
  lcp_link_monitor lcp_link_monitor_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .scl(lcp_link_if_inst.scl), .sda(lcp_link_if_inst.sda), .hw_reset_n(lcp_link_if_inst.hw_reset_n),
    .dev_sda_oe_n(lcp_link_if_inst.dev_sda_oe_n));

  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic ran_out();
    n_fail++;
    $display("wrong value at %0t: wait ran out", $time);
    results();
  endtask

  // Power outputs packed so one compare covers the whole shutdown set
  function automatic logic [7:0] pwr();
    return {3'h0, shutdown_o, conv_switch_en_o, load_connect_o, led_sink_pins_hiz_o, out_discharge_o};
  endfunction

  // One host command; waits are bounded since a stuck link would hang the run
  task automatic cmd(input logic rdn, input logic fast, input logic hs_en, input logic [2:0] p,
                     input logic [7:0] d);
    int i;
    hs = 1'b0;
    for (i = 0; i < LIM && cmd_ready_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (i == LIM) ran_out();
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    cmd_read_i <= rdn;
    cmd_fast_i <= fast;
    cmd_hs_i <= hs_en;
    cmd_ptr_i <= p;
    cmd_data_i <= d;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    for (i = 0; i < LIM; i++) begin
      @(posedge clk_sys_i);
      #1;
      hs = hs | (high_speed_mode_o === 1'b1);
      if (done_o === 1'b1) break;
    end
    if (i == LIM) ran_out();
    rd = rd_data_o;
    nk = nack_o;
  endtask

  // Default register image and the shutdown state
  task automatic chk_def();
    check(cfg_light_o, lcp_pkg::DEF_LIGHT);
    check(cfg_flash2_o, lcp_pkg::DEF_FLASH2);
    check(cfg_flash13_o, lcp_pkg::DEF_FLASH13);
    check(pwr(), PWR_OFF);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk_def();
    cmd(1'b0, 1'b0, 1'b0, 3'h1, 8'h90);
    check({7'h00, nk}, 8'h00);
    check(cfg_flash2_o, 8'h90);
    check(cfg_flash13_o, 8'h88);
    check({6'h00, mode_o}, 8'h02);
    check(pwr(), PWR_ON);
    cmd(1'b1, 1'b1, 1'b0, 3'h1, 8'h00);
    check(rd, 8'h90);
    // Every mode code, each through high-speed entry and exit
    for (int m = 0; m < 4; m++) begin
      cmd(1'b0, 1'b1, 1'b1, 3'h2, {m[1:0], 6'h08});
      check({6'h00, mode_o}, {6'h00, m[1:0]});
      check(pwr(), (m == 0) ? PWR_OFF : PWR_ON);
      check({7'h00, hs}, 8'h01);
      check({7'h00, high_speed_mode_o}, 8'h00);
    end
    // Mode 00 with regulation on must not shut down
    cmd(1'b0, 1'b1, 1'b1, 3'h2, 8'h28);
    check(pwr(), PWR_ON);
    check({7'h00, voltage_regulation_en_o}, 8'h01);
    cmd(1'b1, 1'b1, 1'b1, 3'h5, 8'h00);
    check(rd, 8'h00);
    check({7'h00, nk}, 8'h00);
    cmd(1'b0, 1'b1, 1'b1, 3'h0, 8'h80);
    chk_def();
    cmd(1'b0, 1'b1, 1'b0, 3'h2, 8'h48);
    check(pwr(), PWR_ON);
    // Hardware reset line pulsed with the link idle
    @(posedge clk_sys_i);
    hw_reset_req_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    hw_reset_req_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk_def();
    results();
  end
endmodule // led_driver_serial_control_port_tb_top
